// [shared/eat_pkg.sv]
// package: effective address and move timing constants and types
package eat_pkg;

	// addressing modes, index into the timing tables
	typedef enum logic [4:0] {
		am_data_reg = 5'h00,
		am_addr_reg = 5'h01,
		am_ind = 5'h02,
		am_postinc = 5'h03,
		am_predec = 5'h04,
		am_d16_base = 5'h05,
		am_abs_w = 5'h06,
		am_abs_l = 5'h07,
		am_imm_b = 5'h08,
		am_imm_w = 5'h09,
		am_imm_l = 5'h0a,
		am_d8_idx = 5'h0b,
		am_mi_none = 5'h0c,
		am_mi_d16 = 5'h0d,
		am_mi_d32 = 5'h0e,
		am_mi_base = 5'h0f,
		am_mi_idx = 5'h10,
		am_mi_base_idx = 5'h11,
		am_mi_d16_base = 5'h12,
		am_mi_d32_base = 5'h13,
		am_mi_d16_base_x = 5'h14,
		am_mi_d32_base_x = 5'h15,
		am_mi_d16_base_sx = 5'h16,
		am_mi_d32_base_sx = 5'h17
	} eat_mode_t;

	typedef enum logic [1:0] {
		sz_byte = 2'h0,
		sz_word = 2'h1,
		sz_long = 2'h2
	} eat_size_t;

	typedef enum logic [1:0] {
		op_fetch = 2'h0,
		op_compute = 2'h1,
		op_move = 2'h2
	} eat_op_t;

	// request: base register kind and index size/scale are timing-neutral
	typedef struct packed {
		eat_op_t op;
		eat_mode_t src;
		eat_mode_t dst;
		eat_size_t size;
		logic pc_base;
		logic [1:0] idx_scale;
		logic [4:0] bus_clocks;
	} eat_req_t;

	// signed head/tail, total cycles, read/prefetch/write counts
	typedef struct packed {
		logic signed [7:0] head;
		logic signed [7:0] tail;
		logic [7:0] cycles;
		logic [3:0] reads;
		logic [3:0] prefetch;
		logic [3:0] writes;
	} eat_time_t;

	localparam logic [4:0] BASE_BUS_CLOCKS = 5'h02;
	localparam logic [7:0] LONG_EXTRA_CLOCKS = 8'h02;
	localparam logic [3:0] X_SHORT = 4'h1;
	localparam logic [3:0] X_LONG = 4'h2;
	localparam logic [7:0] READ_CLOCKS = 8'h02;
	localparam int RESULT_LATENCY = 1;

	// move table entry index, generic entry last
	localparam logic [3:0] MV_RR = 4'h0;
	localparam logic [3:0] MV_FEA_R = 4'h1;
	localparam logic [3:0] MV_R_IND = 4'h2;
	localparam logic [3:0] MV_R_POST = 4'h3;
	localparam logic [3:0] MV_R_PRE = 4'h4;
	localparam logic [3:0] MV_R_CEA = 4'h5;
	localparam logic [3:0] MV_FEA_IND = 4'h6;
	localparam logic [3:0] MV_FEA_POST = 4'h7;
	localparam logic [3:0] MV_FEA_PRE = 4'h8;
	localparam logic [3:0] MV_IMM_CEA = 4'h9;
	localparam logic [3:0] MV_GENERIC = 4'ha;

endpackage : eat_pkg

// [core/eat_timing.sv]
// effective address and move instruction timing calculator
`timescale 1ns/100ps
`default_nettype none

module eat_timing (
	input wire logic clock,
	input wire logic srst,
	input wire logic req_valid,
	input wire eat_pkg::eat_req_t req,
	output logic res_valid,
	output var eat_pkg::eat_time_t res
);
	import eat_pkg::*;

	typedef struct packed {
		logic valid;
		eat_time_t t;
	} eat_state_t;

	eat_state_t state_r;
	eat_state_t state_nxt;

	// ea table row: head, tail, cycles, x read, prefetch, has prefetch adjust
	typedef struct packed {
		logic signed [7:0] head;
		logic signed [7:0] tail;
		logic [7:0] cycles;
		logic xread;
		logic [3:0] prefetch;
		logic slow_adj;
	} eat_row_t;

	// table literals arrive as int, each cut to its field width here
	function automatic eat_row_t row(input int h, input int t, input int c,
		input int x, input int p, input int a);
		row = '{head: 8'(h), tail: 8'(t), cycles: 8'(c), xread: 1'(x),
			prefetch: 4'(p), slow_adj: 1'(a)};
	endfunction

	// fetch-address table, word operand; base register kind ignored
	function automatic eat_row_t fetch_row(input eat_mode_t m);
		case (m)
			am_data_reg, am_addr_reg: fetch_row = row(0, 0, 0, 0, 0, 0);
			am_ind, am_postinc: fetch_row = row(1, 1, 3, 1, 0, 0);
			am_predec: fetch_row = row(2, 2, 4, 1, 0, 0);
			am_d16_base, am_abs_w: fetch_row = row(1, 3, 5, 1, 1, 0);
			am_abs_l: fetch_row = row(1, 5, 7, 1, 2, 0);
			am_imm_b, am_imm_w: fetch_row = row(1, 1, 3, 0, 1, 0);
			am_imm_l: fetch_row = row(1, 3, 5, 0, 2, 0);
			am_d8_idx: fetch_row = row(4, 2, 8, 1, 1, 1);
			am_mi_none: fetch_row = row(2, 2, 6, 1, 1, 1);
			am_mi_d16: fetch_row = row(1, 3, 7, 1, 2, 1);
			am_mi_d32: fetch_row = row(1, 5, 9, 1, 3, 1);
			am_mi_base: fetch_row = row(1, 1, 5, 1, 1, 1);
			am_mi_idx, am_mi_base_idx: fetch_row = row(4, 2, 8, 1, 1, 1);
			am_mi_d16_base: fetch_row = row(1, 3, 7, 1, 2, 1);
			am_mi_d32_base: fetch_row = row(1, 5, 9, 1, 3, 1);
			am_mi_d16_base_x: fetch_row = row(2, 2, 8, 1, 2, 1);
			am_mi_d32_base_x: fetch_row = row(1, 3, 9, 1, 3, 1);
			am_mi_d16_base_sx: fetch_row = row(2, 2, 8, 1, 2, 1);
			am_mi_d32_base_sx: fetch_row = row(1, 3, 9, 1, 3, 1);
			default: fetch_row = row(0, 0, 0, 0, 0, 0);
		endcase
	endfunction

	// compute-address table: fetch timing minus the read
	function automatic eat_row_t compute_row(input eat_mode_t m);
		case (m)
			am_data_reg, am_addr_reg: compute_row = row(0, 0, 0, 0, 0, 0);
			am_ind, am_postinc: compute_row = row(1, 0, 2, 0, 0, 0);
			am_predec: compute_row = row(2, 0, 2, 0, 0, 0);
			am_d16_base, am_abs_w: compute_row = row(1, 1, 3, 0, 1, 0);
			am_abs_l: compute_row = row(1, 3, 5, 0, 2, 0);
			am_imm_b, am_imm_w: compute_row = row(1, 1, 3, 0, 1, 0);
			am_imm_l: compute_row = row(1, 3, 5, 0, 2, 0);
			am_d8_idx: compute_row = row(4, 0, 6, 0, 1, 1);
			am_mi_none: compute_row = row(2, 0, 4, 0, 1, 1);
			am_mi_d16: compute_row = row(1, 1, 5, 0, 2, 1);
			am_mi_d32: compute_row = row(1, 3, 7, 0, 3, 1);
			am_mi_base: compute_row = row(1, 0, 4, 0, 1, 1);
			am_mi_idx, am_mi_base_idx: compute_row = row(4, 0, 6, 0, 1, 1);
			am_mi_d16_base: compute_row = row(1, 1, 5, 0, 2, 1);
			am_mi_d32_base: compute_row = row(1, 3, 7, 0, 3, 1);
			am_mi_d16_base_x: compute_row = row(2, 0, 6, 0, 2, 1);
			am_mi_d32_base_x: compute_row = row(1, 1, 7, 0, 3, 1);
			am_mi_d16_base_sx: compute_row = row(2, 0, 6, 0, 2, 1);
			am_mi_d32_base_sx: compute_row = row(1, 1, 7, 0, 3, 1);
			default: compute_row = row(0, 0, 0, 0, 0, 0);
		endcase
	endfunction

	function automatic logic [3:0] xcount(input eat_size_t s);
		xcount = (s == sz_long) ? X_LONG : X_SHORT;
	endfunction

	// apply long operand, then slower bus to the prefetch part
	function automatic eat_time_t ea_time(input eat_row_t r,
		input eat_size_t s, input logic [4:0] bc);
		eat_time_t t;
		logic signed [7:0] extra;
		logic signed [7:0] spill;
		t.head = r.head;
		t.tail = r.tail;
		t.cycles = r.cycles;
		t.reads = r.xread ? xcount(s) : 4'h0;
		t.prefetch = r.prefetch;
		t.writes = 4'h0;
		if (r.xread && s == sz_long) begin
			t.tail = t.tail + 8'sh02;
			t.cycles = t.cycles + LONG_EXTRA_CLOCKS;
		end
		extra = 8'(bc) - 8'(BASE_BUS_CLOCKS);
		if (r.slow_adj && bc > BASE_BUS_CLOCKS) begin
			// extra clocks per prefetch absorbed by head first
			extra = 8'(signed'(8'(extra) * 8'(r.prefetch)));
			if (extra <= t.head) begin
				t.head = t.head - extra;
			end else begin
				spill = extra - t.head;
				t.head = 8'sh00;
				t.tail = t.tail + spill;
				t.cycles = t.cycles + 8'(spill);
			end
		end
		ea_time = t;
	endfunction

	function automatic logic is_reg(input eat_mode_t m);
		is_reg = (m == am_data_reg) || (m == am_addr_reg);
	endfunction

	function automatic logic is_imm(input eat_mode_t m);
		is_imm = (m == am_imm_b) || (m == am_imm_w) || (m == am_imm_l);
	endfunction

	// first matching move entry, top to bottom
	function automatic logic [3:0] move_entry(input eat_mode_t s,
		input eat_mode_t d);
		if (is_reg(s) && is_reg(d)) move_entry = MV_RR;
		else if (is_reg(d)) move_entry = MV_FEA_R;
		else if (is_reg(s) && d == am_ind) move_entry = MV_R_IND;
		else if (is_reg(s) && d == am_postinc) move_entry = MV_R_POST;
		else if (is_reg(s) && d == am_predec) move_entry = MV_R_PRE;
		else if (is_reg(s)) move_entry = MV_R_CEA;
		else if (d == am_ind) move_entry = MV_FEA_IND;
		else if (d == am_postinc) move_entry = MV_FEA_POST;
		else if (d == am_predec) move_entry = MV_FEA_PRE;
		else if (is_imm(s)) move_entry = MV_IMM_CEA;
		else move_entry = MV_GENERIC;
	endfunction

	function automatic eat_time_t move_time(input eat_req_t q);
		eat_time_t t;
		eat_time_t ea;
		eat_time_t fe;
		logic [3:0] e;
		logic wr;
		e = move_entry(q.src, q.dst);
		fe = '0;
		wr = 1'b1;
		t = '0;
		ea = '0;
		case (e)
			MV_RR: begin
				t.head = 8'sh00; t.tail = 8'sh00; t.cycles = 8'h02; wr = 1'b0;
			end
			MV_FEA_R: begin
				t.head = 8'sh00; t.tail = 8'sh00; t.cycles = 8'h02; wr = 1'b0;
				ea = ea_time(fetch_row(q.src), q.size, q.bus_clocks);
			end
			MV_R_IND: begin
				t.head = 8'sh00; t.tail = 8'sh02; t.cycles = 8'h04;
			end
			MV_R_POST: begin
				t.head = 8'sh01; t.tail = 8'sh01; t.cycles = 8'h05;
			end
			MV_R_PRE: begin
				t.head = 8'sh02; t.tail = 8'sh02; t.cycles = 8'h06;
			end
			MV_R_CEA: begin
				t.head = 8'sh01; t.tail = 8'sh03; t.cycles = 8'h05;
				ea = ea_time(compute_row(q.dst), q.size, q.bus_clocks);
			end
			MV_FEA_IND, MV_FEA_POST, MV_FEA_PRE: begin
				t.head = 8'sh02; t.tail = 8'sh02; t.cycles = 8'h06;
				ea = ea_time(fetch_row(q.src), q.size, q.bus_clocks);
			end
			MV_IMM_CEA: begin
				t.head = 8'sh02; t.tail = 8'sh02; t.cycles = 8'h06;
				ea = ea_time(compute_row(q.dst), q.size, q.bus_clocks);
			end
			default: begin
				// generic: compute the source, fetch the destination
				t.head = 8'sh02; t.tail = 8'sh02; t.cycles = 8'h06;
				ea = ea_time(compute_row(q.src), q.size, q.bus_clocks);
				fe = ea_time(fetch_row(q.dst), q.size, q.bus_clocks);
				ea.cycles = ea.cycles + fe.cycles;
				ea.reads = fe.reads;
				ea.prefetch = ea.prefetch + fe.prefetch;
			end
		endcase
		t.prefetch = 4'h1;
		t.writes = wr ? xcount(q.size) : 4'h0;
		if (wr && q.size == sz_long) begin
			t.tail = t.tail + 8'sh02;
			t.cycles = t.cycles + LONG_EXTRA_CLOCKS;
		end
		// ea portion adds to total and counts; entry keeps head and tail
		t.cycles = t.cycles + ea.cycles;
		t.reads = t.reads + ea.reads;
		t.prefetch = t.prefetch + ea.prefetch;
		move_time = t;
	endfunction

	always_comb begin
		state_nxt = state_r;
		state_nxt.valid = req_valid;
		if (req_valid) begin
			case (req.op)
				op_fetch: state_nxt.t = ea_time(fetch_row(req.src), req.size,
					req.bus_clocks);
				op_compute: state_nxt.t = ea_time(compute_row(req.src),
					req.size, req.bus_clocks);
				op_move: state_nxt.t = move_time(req);
				default: state_nxt.t = '0;
			endcase
		end
		if (srst) begin
			state_nxt = '0;
		end
	end

	always_ff @(posedge clock) begin
		state_r <= state_nxt;
	end

	assign res_valid = state_r.valid;
	assign res = state_r.t;

endmodule // eat_timing

`default_nettype wire

// [bench/eat_mem_bus.sv]
// partner: memory bus speed seen by the timing block
`timescale 1ns/100ps
`default_nettype none

module eat_mem_bus (
	input wire logic [2:0] wait_states,
	output logic [4:0] bus_clocks
);
	// two-clock access plus any wait states
	always_comb begin
		bus_clocks = 5'h02 + {2'h0, wait_states};
	end
endmodule // eat_mem_bus

`default_nettype wire

// [bench/eat_timing_assertions.sv]
// checker: result timing and table figures at the ports
`timescale 1ns/100ps
`default_nettype none

module eat_timing_assertions
	import eat_pkg::*;
(
	input wire logic clock,
	input wire logic srst,
	input wire logic req_valid,
	input wire eat_pkg::eat_req_t req,
	input wire logic res_valid,
	input wire eat_pkg::eat_time_t res
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);
	logic base;
	assign base = req_valid && req.bus_clocks == 5'h02 && req.size != sz_long;

	property p_ans; req_valid |=> res_valid; endproperty
	a_ans: assert property (p_ans) else $error("result missing");
	property p_quiet; !req_valid |=> !res_valid && $stable(res); endproperty
	a_quiet: assert property (p_quiet) else $error("spurious result");
	property p_rst; disable iff (1'b0) srst |=> !res_valid && res == '0;
	endproperty
	a_rst: assert property (p_rst) else $error("reset not clean");
	property p_d8; base && req.op == op_fetch && req.src == am_d8_idx |=>
		res.head == 4 && res.tail == 2 && res.cycles == 8 && res.prefetch == 1;
	endproperty
	a_d8: assert property (p_d8) else $error("d8 index fetch");
	property p_d16; base && req.op == op_compute && req.src == am_mi_d16_base_x
		|=> res.head == 2 && res.tail == 0 && res.cycles == 6
		&& res.prefetch == 2;
	endproperty
	a_d16: assert property (p_d16) else $error("d16 index compute");
	property p_d32; base && req.op == op_fetch && req.src == am_mi_d32_base_x
		|=> res.head == 1 && res.tail == 3 && res.cycles == 9
		&& res.prefetch == 3;
	endproperty
	a_d32: assert property (p_d32) else $error("d32 index fetch");
	property p_sx; base && req.op == op_fetch && req.src == am_mi_d16_base_sx
		|=> res.head == 2 && res.tail == 2 && res.cycles == 8;
	endproperty
	a_sx: assert property (p_sx) else $error("scaled index fetch");
	property p_long; req_valid && req.op == op_fetch && req.src == am_ind &&
		req.size == sz_long |=> res.reads == 2 && res.tail == 3 && res.cycles == 5;
	endproperty
	a_long: assert property (p_long) else $error("long operand");
	property p_cmp; req_valid && req.op == op_compute |=> res.reads == 0;
	endproperty
	a_cmp: assert property (p_cmp) else $error("compute read");
	property p_nowr; req_valid && req.op != op_move |=> res.writes == 0;
	endproperty
	a_nowr: assert property (p_nowr) else $error("address write");
	property p_slow; req_valid && req.op == op_fetch && req.src == am_d8_idx &&
		req.size != sz_long && req.bus_clocks == 5'h06 |=> res.head == 0
		&& res.tail == 2 && res.cycles == 8;
	endproperty
	a_slow: assert property (p_slow) else $error("slow bus head");
	c_move: cover property (req_valid && req.op == op_move);
	c_slow: cover property (req_valid && req.bus_clocks > 5'h02);
	c_long: cover property (req_valid && req.size == sz_long);
endmodule // eat_timing_assertions

bind eat_timing eat_timing_assertions u_eat_timing_assertions (.clock(clock),
	.srst(srst), .req_valid(req_valid), .req(req), .res_valid(res_valid),
	.res(res));

`default_nettype wire

// [bench/eat_timing_tb.sv]
// testbench: random address and move timing against a behavioural model
`timescale 1ns/100ps
`default_nettype none

module eat_timing_tb;
	import eat_pkg::*;
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic req_valid = 1'b0;
	eat_req_t req = '0;
	eat_req_t req_in;
	logic [2:0] wait_states = 3'h0;
	logic [4:0] bus_clocks;
	logic res_valid;
	eat_time_t res;
	eat_time_t want = '0;
	eat_time_t last = '0;
	bit pend = 0;
	int fail_count = 0;
	int checks_done = 0;
	eat_mode_t pool[11] = '{am_data_reg, am_ind, am_predec, am_abs_l,
		am_d8_idx, am_mi_d16_base_x, am_mi_d32_base_x, am_mi_d16_base_sx,
		am_postinc, am_imm_l, am_mi_none};
	eat_mode_t msrc[5] = '{am_data_reg, am_data_reg, am_data_reg, am_predec,
		am_d8_idx};
	eat_mode_t mdst[5] = '{am_addr_reg, am_ind, am_d8_idx, am_data_reg,
		am_mi_d16_base_x};

	always #20 clock = ~clock;
	always_comb begin
		req_in = req;
		req_in.bus_clocks = bus_clocks;
	end
	eat_mem_bus u_eat_mem_bus (.wait_states(wait_states),
		.bus_clocks(bus_clocks));
	eat_timing u_eat_timing (.clock(clock), .srst(srst), .req_valid(req_valid),
		.req(req_in), .res_valid(res_valid), .res(res));

	function automatic eat_time_t ea(bit cmp, eat_mode_t m, eat_size_t s,
		int bc);
		int v[9];
		int h, t, c, e, r;
		eat_time_t o;
		case (m)
		am_ind, am_postinc: v = '{1, 1, 3, 1, 0, 2, 0, 1, 0};
		am_imm_l: v = '{1, 3, 5, 1, 3, 5, 2, 0, 0};
		am_mi_none: v = '{2, 2, 6, 2, 0, 4, 1, 1, 1};
		am_predec: v = '{2, 2, 4, 2, 0, 2, 0, 1, 0};
		am_abs_l: v = '{1, 5, 7, 1, 3, 5, 2, 1, 0};
		am_d8_idx: v = '{4, 2, 8, 4, 0, 6, 1, 1, 1};
		am_mi_d16_base_x, am_mi_d16_base_sx: v = '{2, 2, 8, 2, 0, 6, 2, 1, 1};
		am_mi_d32_base_x: v = '{1, 3, 9, 1, 1, 7, 3, 1, 1};
		default: v = '{default: 0};
		endcase
		h = cmp ? v[3] : v[0];
		t = cmp ? v[4] : v[1];
		c = cmp ? v[5] : v[2];
		r = (!cmp && v[7] != 0) ? ((s == sz_long) ? 2 : 1) : 0;
		if (r == 2) begin
			t += 2;
			c += 2;
		end
		e = (v[8] != 0) ? (bc - 2) * v[6] : 0;
		// extra prefetch clocks eat the head first
		if (e > h) begin
			t += e - h;
			c += e - h;
			h = 0;
		end else begin
			h -= e;
		end
		o = '0;
		o.head = 8'(h);
		o.tail = 8'(t);
		o.cycles = 8'(c);
		o.reads = 4'(r);
		o.prefetch = 4'(v[6]);
		return o;
	endfunction

	function automatic eat_time_t mv(eat_mode_t sm, eat_mode_t dm,
		eat_size_t s);
		eat_time_t o, a, b;
		bit sr, dr;
		int w;
		sr = sm <= am_addr_reg;
		dr = dm <= am_addr_reg;
		a = '0;
		b = '0;
		o = '0;
		o.prefetch = 4'h1;
		o.cycles = 8'h02;
		w = dr ? 0 : ((s == sz_long) ? 2 : 1);
		if (dr && !sr) a = ea(0, sm, s, 2);
		else if (sr && dm == am_ind) begin
			o.tail = 8'h02;
			o.cycles = 8'h04;
		end else if (sr && !dr) begin
			o = '{8'h01, 8'h03, 8'h05, 4'h0, 4'h1, 4'h0};
			a = ea(1, dm, s, 2);
		end else if (!dr) begin
			o = '{8'h02, 8'h02, 8'h06, 4'h0, 4'h1, 4'h0};
			a = ea(1, sm, s, 2);
			b = ea(0, dm, s, 2);
		end
		if (w == 2) begin
			o.tail += 8'h02;
			o.cycles += 8'h02;
		end
		o.writes = 4'(w);
		o.cycles += a.cycles + b.cycles;
		o.reads = a.reads + b.reads;
		o.prefetch += a.prefetch + b.prefetch;
		return o;
	endfunction

	task automatic check(logic [35:0] seen, logic [35:0] exp, string what);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %0t %s seen %h want %h", $time, what, seen, exp);
		end
	endtask

	task automatic step(bit go, eat_op_t op, eat_mode_t sm, eat_mode_t dm,
		logic [2:0] ws);
		eat_size_t sz;
		@(negedge clock);
		if (pend) begin
			check(36'(res_valid), 36'h1, "valid");
			check(res, want, "result");
			last = want;
		end else begin
			check(36'(res_valid), 36'h0, "idle");
			check(res, last, "hold");
		end
		sz = eat_size_t'($urandom_range(0, 2));
		req_valid = go;
		req.op = op;
		req.src = sm;
		req.dst = dm;
		req.size = sz;
		req.pc_base = 1'($urandom);
		req.idx_scale = 2'($urandom);
		wait_states = ws;
		want = (op == op_move) ? mv(sm, dm, sz)
			: ea(op == op_compute, sm, sz, 2 + int'(ws));
		pend = go;
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	initial begin
		int k;
		void'($urandom(15801));
		repeat (10) @(negedge clock);
		srst = 1'b0;
		for (int i = 0; i < 900; i++) begin
			step($urandom_range(0, 3) != 0, eat_op_t'($urandom_range(0, 1)),
				pool[$urandom_range(0, 10)], am_data_reg,
				$urandom_range(0, 1) ? 3'h0 : 3'($urandom_range(1, 5)));
		end
		$display("address timing test done");
		for (int i = 0; i < 200; i++) begin
			k = $urandom_range(0, 4);
			step($urandom_range(0, 3) != 0, op_move, msrc[k], mdst[k], 3'h0);
		end
		$display("move timing test done");
		@(negedge clock);
		srst = 1'b1;
		req_valid = 1'b0;
		repeat (2) @(negedge clock);
		srst = 1'b0;
		pend = 0;
		last = '0;
		for (int i = 0; i < 20; i++) step(1, op_fetch, am_d8_idx, am_data_reg, 3'h4);
		step(0, op_fetch, am_ind, am_data_reg, 3'h0);
		$display("second reset test done");
		wrap_up();
	end
endmodule // eat_timing_tb

`default_nettype wire
